// File: hdl/ofp_retry_timer.sv
// Purpose: Measures the delay between two restart attempts.
// Assumes: start is a one-cycle pulse; a restart reloads an active count.
// Notes: A 1 ms enable divides the clock; ms are then counted.
`timescale 1ns/1ps
module ofp_retry_timer #(
  parameter int TICK_CYCLES = ofp_pkg::MS_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Control.
  input wire logic start,
  input wire logic abort,
  input wire logic [2:0] retry_time,
  // Result.
  output logic done
);

  localparam int PW = $clog2(TICK_CYCLES + 1);
  localparam int MW = ofp_pkg::RETRY_MS_W;

  logic [PW-1:0] pre_q; // Prescaler toward one millisecond.
  logic [MW-1:0] ms_q; // Milliseconds still to wait.
  logic busy_q; // Delay in progress.
  logic [MW-1:0] target; // Whole delay in milliseconds.

  // Delay is (value + 1) steps of 35 ms.
  assign target = MW'(({6'h00, retry_time} + 9'h001) *
                      MW'(ofp_pkg::RETRY_STEP_MS));

  // Prescaler and millisecond counter share one process.
  always_ff @(posedge clk) begin
    done <= 1'b0;
    if (sys_rst || abort) begin
      pre_q <= '0;
      ms_q <= '0;
      busy_q <= 1'b0;
    end else if (start) begin
      pre_q <= PW'(TICK_CYCLES - 1);
      ms_q <= target;
      busy_q <= 1'b1;
    end else if (busy_q) begin
      if (pre_q != '0) begin
        pre_q <= pre_q - 1'b1;
      end else begin
        // One millisecond has passed.
        pre_q <= PW'(TICK_CYCLES - 1);
        if (ms_q == MW'(1)) begin
          busy_q <= 1'b0;
          done <= 1'b1;
          ms_q <= '0;
        end else begin
          ms_q <= ms_q - 1'b1;
        end
      end
    end
  end

endmodule

// File: hdl/ofp_top.sv
// Purpose: Output undervoltage, overcurrent and undercurrent protection.
// Assumes: Sensed codes share clk and the thresholds' number format.
// Notes: Register access is by command code from the bus engine.
`timescale 1ns/1ps
module ofp_top #(
  parameter int TICK_CYCLES = ofp_pkg::MS_CYCLES
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Command port from the bus engine.
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_is_word,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic rsp_valid,
  output logic rsp_err,
  output logic [15:0] rsp_rdata,
  // Sensed values, same clock domain.
  input wire logic [15:0] vout_sense,
  input wire logic [15:0] phase_a_ipeak,
  input wire logic [15:0] phase_b_ipeak,
  // Control pins and system events.
  input wire logic output_enable_pin,
  input wire logic bias_ok_pin,
  input wire logic clear_faults,
  input wire logic other_fault,
  // Output stage control and status.
  output logic output_on,
  output logic power_good_out,
  output logic uv_fault_flag,
  output logic oc_fault_flag,
  output logic uc_fault_flag,
  // Open-drain alert line.
  input wire logic alert_line_n_i,
  output logic alert_line_n_o,
  output logic alert_line_n_oe,
  output logic alert_line_low_seen
);

  // Register contents.
  logic [15:0] uv_limit_q; // Undervoltage threshold.
  logic [7:0] uv_resp_q; // Undervoltage response byte.
  logic [15:0] oc_limit_q; // Per-phase overcurrent threshold.
  logic [15:0] uc_limit_q; // Per-phase undercurrent threshold.

  // Pin synchronisers; only stage two is read by logic.
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic en_s;
  logic bias_s;

  // Fault detection and sequencing.
  ofp_pkg::ofp_state_e state_q;
  logic [2:0] tries_q; // Restarts already made.
  logic uv_now; // Output below threshold while on.
  logic oc_now; // Either phase above overcurrent threshold.
  logic uc_now; // Either phase below undercurrent threshold.
  logic [1:0] mode;
  logic [2:0] retry_set;
  logic [2:0] retry_time;
  logic timer_start;
  logic timer_abort;
  logic timer_done;
  logic size_ok; // Access size matches the command.
  logic known; // Command code belongs to this block.

  assign mode = uv_resp_q[ofp_pkg::RESP_MODE_HI:ofp_pkg::RESP_MODE_LO];
  assign retry_set =
    uv_resp_q[ofp_pkg::RESP_RETRY_HI:ofp_pkg::RESP_RETRY_LO];
  assign retry_time =
    uv_resp_q[ofp_pkg::RESP_TIME_HI:ofp_pkg::RESP_TIME_LO];
  assign en_s = sync2_q[0];
  assign bias_s = sync2_q[1];

  // Control pins come from outside, so two flops precede any use.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {~alert_line_n_i, bias_ok_pin, output_enable_pin};
      sync2_q <= sync1_q;
    end
  end

  // Level of the shared alert wire, whoever pulls it.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alert_line_low_seen <= 1'b0;
    end else begin
      alert_line_low_seen <= sync2_q[2];
    end
  end

  // Undervoltage only counts while the output is driven; a stopped
  // output is low by design and must not re-trigger the response.
  assign uv_now = (state_q == ofp_pkg::ST_RUN) &&
                  (vout_sense < uv_limit_q);
  // Each phase is judged alone, so the total limit is twice the value.
  assign oc_now = (phase_a_ipeak > oc_limit_q) ||
                  (phase_b_ipeak > oc_limit_q);
  assign uc_now = (phase_a_ipeak < uc_limit_q) ||
                  (phase_b_ipeak < uc_limit_q);

  // Command decode and size check.
  always_comb begin
    known = 1'b1;
    size_ok = cmd_is_word;
    case (cmd_code)
      ofp_pkg::CMD_UV_LIMIT: size_ok = cmd_is_word;
      ofp_pkg::CMD_UV_RESPONSE: size_ok = !cmd_is_word;
      ofp_pkg::CMD_OC_LIMIT: size_ok = cmd_is_word;
      ofp_pkg::CMD_UC_LIMIT: size_ok = cmd_is_word;
      default: known = 1'b0;
    endcase
  end

  // Register writes; a wrongly sized access changes nothing.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      uv_limit_q <= ofp_pkg::RST_UV_LIMIT;
      uv_resp_q <= ofp_pkg::RST_UV_RESPONSE;
      oc_limit_q <= ofp_pkg::RST_OC_LIMIT;
      uc_limit_q <= ofp_pkg::RST_UC_LIMIT;
    end else if (cmd_valid && cmd_write && known && size_ok) begin
      case (cmd_code)
        ofp_pkg::CMD_UV_LIMIT: uv_limit_q <= cmd_wdata;
        ofp_pkg::CMD_UV_RESPONSE: uv_resp_q <= cmd_wdata[7:0];
        ofp_pkg::CMD_OC_LIMIT: oc_limit_q <= cmd_wdata;
        ofp_pkg::CMD_UC_LIMIT: uc_limit_q <= cmd_wdata;
        default: uv_limit_q <= uv_limit_q;
      endcase
    end
  end

  // Answer one cycle after each request; byte reads fill low bits.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
      rsp_err <= 1'b0;
      rsp_rdata <= '0;
    end else begin
      rsp_valid <= cmd_valid;
      rsp_err <= cmd_valid && !(known && size_ok);
      rsp_rdata <= '0;
      if (cmd_valid && !cmd_write && known && size_ok) begin
        case (cmd_code)
          ofp_pkg::CMD_UV_LIMIT: rsp_rdata <= uv_limit_q;
          ofp_pkg::CMD_UV_RESPONSE: rsp_rdata <= {8'h00, uv_resp_q};
          ofp_pkg::CMD_OC_LIMIT: rsp_rdata <= oc_limit_q;
          ofp_pkg::CMD_UC_LIMIT: rsp_rdata <= uc_limit_q;
          default: rsp_rdata <= '0;
        endcase
      end
    end
  end

  // Sticky fault flags; a new fault wins over a clear in the same cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      uv_fault_flag <= 1'b0;
      oc_fault_flag <= 1'b0;
      uc_fault_flag <= 1'b0;
    end else begin
      uv_fault_flag <= uv_now || (uv_fault_flag && !clear_faults);
      oc_fault_flag <= oc_now || (oc_fault_flag && !clear_faults);
      uc_fault_flag <= uc_now || (uc_fault_flag && !clear_faults);
    end
  end

  // Alert pulls low while any fault stays recorded, in every mode.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      alert_line_n_o <= 1'b0;
      alert_line_n_oe <= 1'b0;
    end else begin
      alert_line_n_o <= 1'b0;
      alert_line_n_oe <= uv_now || oc_now || uc_now ||
        ((uv_fault_flag || oc_fault_flag || uc_fault_flag) &&
         !clear_faults);
    end
  end

  // Sequencer for shutdown and restart after an undervoltage fault.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ofp_pkg::ST_OFF;
      tries_q <= '0;
    end else begin
      case (state_q)
        ofp_pkg::ST_OFF: begin
          tries_q <= '0;
          if (en_s && bias_s) begin
            state_q <= ofp_pkg::ST_RUN;
          end
        end
        ofp_pkg::ST_RUN: begin
          if (!en_s || !bias_s) begin
            state_q <= ofp_pkg::ST_OFF;
          end else if (other_fault) begin
            state_q <= ofp_pkg::ST_LATCH;
          end else if (uv_now && mode == ofp_pkg::MODE_DISABLE_RETRY) begin
            // Output stops at once; retry budget decides what follows.
            if (retry_set == ofp_pkg::RETRY_NONE) begin
              state_q <= ofp_pkg::ST_LATCH;
            end else if (retry_set == ofp_pkg::RETRY_FOREVER) begin
              state_q <= ofp_pkg::ST_WAIT;
            end else if (tries_q < retry_set) begin
              state_q <= ofp_pkg::ST_WAIT;
              tries_q <= tries_q + 1'b1;
            end else begin
              state_q <= ofp_pkg::ST_LATCH;
            end
          end else if (uv_now && mode == ofp_pkg::MODE_DISABLE_LATCH) begin
            state_q <= ofp_pkg::ST_LATCH;
          end
        end
        ofp_pkg::ST_WAIT: begin
          if (!en_s || !bias_s) begin
            state_q <= ofp_pkg::ST_OFF;
          end else if (other_fault) begin
            state_q <= ofp_pkg::ST_LATCH;
          end else if (timer_done) begin
            state_q <= ofp_pkg::ST_RUN;
          end
        end
        ofp_pkg::ST_LATCH: begin
          // Stays off until the fault is cleared or output disabled.
          if (clear_faults || !en_s) begin
            state_q <= ofp_pkg::ST_OFF;
            tries_q <= '0;
          end
        end
        default: state_q <= ofp_pkg::ST_OFF;
      endcase
    end
  end

  // Delay starts on the cycle the sequencer enters the wait.
  assign timer_start = (state_q == ofp_pkg::ST_RUN) && en_s && bias_s &&
    !other_fault && uv_now && (mode == ofp_pkg::MODE_DISABLE_RETRY) &&
    (retry_set != ofp_pkg::RETRY_NONE) &&
    ((retry_set == ofp_pkg::RETRY_FOREVER) || (tries_q < retry_set));
  assign timer_abort = (state_q != ofp_pkg::ST_WAIT) && !timer_start;

  ofp_retry_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .clk(clk),
    .sys_rst(sys_rst),
    .start(timer_start),
    .abort(timer_abort),
    .retry_time(retry_time),
    .done(timer_done)
  );

  // Output stage follows the sequencer; it drops in the fault cycle.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      output_on <= 1'b0;
    end else begin
      output_on <= (state_q == ofp_pkg::ST_OFF) ? (en_s && bias_s) :
        (state_q == ofp_pkg::ST_WAIT) ? (timer_done && en_s && bias_s &&
                                         !other_fault) :
        (state_q == ofp_pkg::ST_RUN) ? (en_s && bias_s && !other_fault &&
          !(uv_now && mode[1])) : 1'b0;
    end
  end

  // Power good follows the same threshold as the undervoltage fault.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_good_out <= 1'b0;
    end else begin
      power_good_out <= (state_q == ofp_pkg::ST_RUN) &&
                        (vout_sense >= uv_limit_q);
    end
  end

endmodule

// File: pkg/ofp_pkg.sv
// Purpose: Constants for the output fault protection block.
// Assumes: 40 MHz clock; command codes arrive from a separate bus engine.
// Notes: Constants only; operation is described in the modules.
package ofp_pkg;

  // Command codes of the four registers.
  localparam logic [7:0] CMD_UV_LIMIT = 8'h44;
  localparam logic [7:0] CMD_UV_RESPONSE = 8'h45;
  localparam logic [7:0] CMD_OC_LIMIT = 8'h46;
  localparam logic [7:0] CMD_UC_LIMIT = 8'h4B;

  // Field positions inside the response byte.
  localparam int RESP_MODE_HI = 7;
  localparam int RESP_MODE_LO = 6;
  localparam int RESP_RETRY_HI = 5;
  localparam int RESP_RETRY_LO = 3;
  localparam int RESP_TIME_HI = 2;
  localparam int RESP_TIME_LO = 0;

  // Response mode and retry setting encodings.
  localparam logic [1:0] MODE_DISABLE_RETRY = 2'h2;
  localparam logic [1:0] MODE_DISABLE_LATCH = 2'h3;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Reset values of the registers.
  localparam logic [15:0] RST_UV_LIMIT = 16'h0000;
  localparam logic [7:0] RST_UV_RESPONSE = 8'h80;
  localparam logic [15:0] RST_OC_LIMIT = 16'hFFFF;
  localparam logic [15:0] RST_UC_LIMIT = 16'h0000;

  // Timing: clock rate and retry step.
  localparam int CLK_HZ = 40_000_000;
  localparam int MS_PER_S = 1000;
  localparam int RETRY_STEP_MS = 35;
  localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int RETRY_MS_W = 9;

  // Retry controller states, Gray coded along off, run, wait.
  typedef enum logic [1:0] {
    ST_OFF = 2'h0,
    ST_RUN = 2'h1,
    ST_WAIT = 2'h3,
    ST_LATCH = 2'h2
  } ofp_state_e;

endpackage

// File: testbench/ofp_chk.sv
// Purpose: Port checker for the output fault protection block.
// Assumes: The response byte is tracked from byte writes on the port.
// Notes: Bound to every instance of the top module.
`timescale 1ns/1ps
module ofp_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic sys_rst,
  // Command port.
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic cmd_is_word,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_rdata,
  // Events and status.
  input wire logic clear_faults,
  input wire logic output_on,
  input wire logic power_good_out,
  input wire logic uv_fault_flag,
  input wire logic oc_fault_flag,
  input wire logic uc_fault_flag,
  input wire logic alert_line_n_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Shadow of the response byte, so mode bits are known here.
  logic [7:0] resp_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      resp_q <= ofp_pkg::RST_UV_RESPONSE;
    end else if (cmd_valid && cmd_write && !cmd_is_word &&
                 cmd_code == ofp_pkg::CMD_UV_RESPONSE) begin
      resp_q <= cmd_wdata[7:0];
    end
  end
  // A retry delay is never shorter than eight cycles.
  sequence s_off_hold;
    !output_on [*8];
  endsequence
  property p_rsp; rsp_valid == $past(cmd_valid); endproperty
  property p_size;
    cmd_valid && cmd_is_word && cmd_code == ofp_pkg::CMD_UV_RESPONSE
      |=> rsp_valid && rsp_err;
  endproperty
  property p_err_data; rsp_err |-> rsp_rdata == 16'h0000; endproperty
  property p_alert;
    $rose(uv_fault_flag) || $rose(oc_fault_flag) || $rose(uc_fault_flag)
      |-> alert_line_n_oe;
  endproperty
  property p_pg; $rose(uv_fault_flag) |-> !power_good_out; endproperty
  property p_shut; $rose(uv_fault_flag) && resp_q[7] |-> !output_on;
  endproperty
  property p_off;
    $fell(output_on) && resp_q[7:6] == 2'h2 |=> s_off_hold;
  endproperty
  property p_uv_stick;
    uv_fault_flag && !clear_faults && !$past(clear_faults)
      |=> uv_fault_flag;
  endproperty
  property p_oc_stick;
    $fell(oc_fault_flag) |-> $past(clear_faults) || $past(clear_faults, 2);
  endproperty
  a_rsp: assert property (p_rsp) else $error("no answer");
  a_size: assert property (p_size) else $error("size kept");
  a_err_data: assert property (p_err_data) else $error("err data");
  a_alert: assert property (p_alert) else $error("no alert");
  a_pg: assert property (p_pg) else $error("pg high");
  a_shut: assert property (p_shut) else $error("still on");
  a_off: assert property (p_off) else $error("short delay");
  a_uv_stick: assert property (p_uv_stick) else $error("uv lost");
  a_oc_stick: assert property (p_oc_stick) else $error("oc lost");
endmodule
bind ofp_top ofp_chk u_chk (.clk, .sys_rst, .cmd_valid, .cmd_write,
  .cmd_is_word, .cmd_code, .cmd_wdata, .rsp_valid, .rsp_err, .rsp_rdata,
  .clear_faults, .output_on, .power_good_out, .uv_fault_flag,
  .oc_fault_flag, .uc_fault_flag, .alert_line_n_oe);

// File: testbench/ofp_host.sv
// Purpose: Host model that issues register commands.
// Assumes: The answer comes one cycle after the request edge.
// Notes: Idle code and data lines are inverted so stale values never help.
`timescale 1ns/1ps
module ofp_host (
  // Clock.
  input wire logic clk,
  // Request.
  output logic cmd_valid,
  output logic cmd_write,
  output logic cmd_is_word,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  // Answer.
  input wire logic rsp_valid,
  input wire logic rsp_err,
  input wire logic [15:0] rsp_rdata
);
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_is_word = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // One transfer; bad flips the access size to provoke a refusal.
  task automatic xfer(input logic wr, input logic bad, input logic [7:0] c,
    input logic [15:0] wd, output logic [15:0] rd, output logic [1:0] st);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = wr;
    cmd_is_word = (c != ofp_pkg::CMD_UV_RESPONSE) ^ bad;
    cmd_code = c;
    cmd_wdata = wd;
    @(posedge clk);
    #1;
    cmd_valid = 1'b0;
    cmd_code = ~cmd_code;
    cmd_wdata = ~cmd_wdata;
    rd = rsp_rdata;
    st = {rsp_valid, rsp_err};
  endtask
endmodule

// File: testbench/output_fault_protection_tb_top.sv
// Purpose: Self-checking bench for the output fault protection block.
// Assumes: A short millisecond so retry delays stay brief.
// Notes: Register and flag values come from a model in the bench.
`timescale 1ns/1ps
module output_fault_protection_tb_top;
  localparam int TICK = 4;
  localparam int STEP = 35 * TICK;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic cmd_valid, cmd_write, cmd_is_word, rsp_valid, rsp_err;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_rdata, rd;
  logic [15:0] vout_sense, phase_a_ipeak, phase_b_ipeak;
  logic output_enable_pin, bias_ok_pin, other_fault, clear_faults;
  logic output_on, power_good_out, e_oc, e_uc, ok;
  logic uv_fault_flag, oc_fault_flag, uc_fault_flag;
  logic alert_line_n_o, alert_line_n_oe, alert_line_low_seen;
  logic [1:0] st;
  wire alert_line_n_i;
  int n_errors = 0;
  int checks = 0;
  int regs[4]; // Model of the four registers.
  logic [7:0] codes[4] = '{ofp_pkg::CMD_UV_LIMIT, ofp_pkg::CMD_UV_RESPONSE,
    ofp_pkg::CMD_OC_LIMIT, ofp_pkg::CMD_UC_LIMIT};
  int md[6] = '{2, 2, 2, 2, 3, 0}; // Response mode of each case.
  int rs[6] = '{0, 1, 3, 7, 3, 3}; // Retry setting of each case.
  int n, gap, t, d;
  logic prev;
  // The alert wire has a pull-up, so it is high unless someone pulls.
  assign alert_line_n_i = alert_line_n_oe ? alert_line_n_o : 1'b1;
  always #12.5 clk = ~clk;
  ofp_top #(.TICK_CYCLES(TICK)) u_dut (.clk, .sys_rst, .cmd_valid,
    .cmd_write, .cmd_is_word, .cmd_code, .cmd_wdata, .rsp_valid, .rsp_err,
    .rsp_rdata, .vout_sense, .phase_a_ipeak, .phase_b_ipeak,
    .output_enable_pin, .bias_ok_pin, .clear_faults,
    .other_fault, .output_on, .power_good_out, .uv_fault_flag,
    .oc_fault_flag, .uc_fault_flag, .alert_line_n_i, .alert_line_n_o,
    .alert_line_n_oe, .alert_line_low_seen);
  ofp_host u_host (.clk, .cmd_valid, .cmd_write, .cmd_is_word, .cmd_code,
    .cmd_wdata, .rsp_valid, .rsp_err, .rsp_rdata);
  // Compare one value and count it.
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // A hang costs a mismatch and ends the run.
  initial begin
    #(25 * 40000);
    n_errors++;
    conclude();
  end
  initial begin
    void'($urandom(93318));
    vout_sense = 16'hFFFF;
    phase_a_ipeak = 16'h4000;
    phase_b_ipeak = 16'h4000;
    output_enable_pin = 1'b1;
    bias_ok_pin = 1'b1;
    other_fault = 1'b0;
    clear_faults = 1'b0;
    regs = '{ofp_pkg::RST_UV_LIMIT, ofp_pkg::RST_UV_RESPONSE,
      ofp_pkg::RST_OC_LIMIT, ofp_pkg::RST_UC_LIMIT};
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    for (int i = 0; i < 4; i++) begin
      u_host.xfer(1'b0, 1'b0, codes[i], 16'h0000, rd, st);
      chk("reset value", regs[i], rd);
      chk("status", 16'h0002, st);
    end
    u_host.xfer(1'b1, 1'b1, codes[1], 16'h00C0, rd, st);
    chk("wrong size", 16'h0003, st);
    u_host.xfer(1'b0, 1'b0, 8'h47, 16'h0000, rd, st);
    chk("unknown code", 16'h0003, st);
    regs[0] = 16'h4000;
    regs[2] = 16'h8000 | $urandom_range(16'h0FFF);
    regs[3] = $urandom_range(16'h0FFF, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      u_host.xfer(1'b1, 1'b0, codes[i], regs[i], rd, st);
      u_host.xfer(1'b0, 1'b0, codes[i], 16'h0000, rd, st);
      chk("readback", regs[i], rd);
    end
    $display("test registers done");
    for (int k = 0; k < 16; k++) begin
      @(posedge clk);
      #1;
      phase_a_ipeak = $urandom_range(16'h9000);
      phase_b_ipeak = $urandom_range(16'h9000);
      // The first two rounds force one trip of each limit.
      if (k == 0) phase_a_ipeak = 16'hFFFF;
      if (k == 1) phase_b_ipeak = 16'h0000;
      e_oc = phase_a_ipeak > regs[2] || phase_b_ipeak > regs[2];
      e_uc = phase_a_ipeak < regs[3] || phase_b_ipeak < regs[3];
      repeat (2) @(posedge clk);
      #1;
      chk("oc", e_oc, oc_fault_flag);
      chk("uc", e_uc, uc_fault_flag);
      chk("alert", e_oc | e_uc, alert_line_n_oe);
      phase_a_ipeak = 16'h4000;
      phase_b_ipeak = 16'h4000;
      clear_faults = 1'b1;
      @(posedge clk);
      #1 clear_faults = 1'b0;
      repeat (3) @(posedge clk);
    end
    $display("test currents done");
    foreach (rs[j]) begin
      t = $urandom_range(1);
      d = (t + 1) * STEP;
      regs[1] = {md[j][1:0], rs[j][2:0], t[2:0]};
      u_host.xfer(1'b1, 1'b0, codes[1], regs[1], rd, st);
      chk("pg before", 16'h0001, power_good_out);
      vout_sense = 16'h3FFF;
      repeat (2) @(posedge clk);
      #1;
      chk("uv", 16'h0001, uv_fault_flag);
      chk("off", md[j] >= 2 ? 16'h0000 : 16'h0001, output_on);
      chk("pg", 16'h0000, power_good_out);
      chk("wire", 16'h0000, alert_line_n_i);
      n = 0;
      gap = 0;
      prev = output_on;
      for (int c = 0; c < 9 * d; c++) begin
        @(posedge clk);
        #1;
        if (output_on === 1'b1 && !prev) begin
          if (n == 0) gap = c;
          n++;
        end
        prev = output_on;
      end
      if (md[j] == 2 && rs[j] != 0) begin
        chk("gap", 1, gap >= d - 2 && gap <= d + 1);
      end
      // Only mode 10 restarts; the other modes never restart.
      ok = md[j] != 2 ? n == 0 : rs[j] == 7 ? n >= 8 : n == rs[j];
      chk("restarts", 1, ok);
      chk("low seen", 16'h0001, alert_line_low_seen);
      vout_sense = 16'hFFFF;
      clear_faults = 1'b1;
      @(posedge clk);
      #1 clear_faults = 1'b0;
      for (int c = 0; c < d + 10 && output_on !== 1'b1; c++) begin
        @(posedge clk);
        #1;
      end
      chk("on again", 16'h0001, output_on);
    end
    $display("test undervoltage done");
    // Endless retry still stops for another fault, enable or bias loss.
    for (int s = 0; s < 3; s++) begin
      regs[1] = {2'b10, ofp_pkg::RETRY_FOREVER, 3'b000};
      u_host.xfer(1'b1, 1'b0, codes[1], regs[1], rd, st);
      vout_sense = 16'h3FFF;
      repeat (STEP / 2) @(posedge clk);
      #1;
      other_fault = (s == 0);
      output_enable_pin = (s != 1);
      bias_ok_pin = (s != 2);
      n = 0;
      prev = output_on;
      for (int c = 0; c < 3 * STEP; c++) begin
        @(posedge clk);
        #1;
        if (output_on === 1'b1 && !prev) n++;
        prev = output_on;
      end
      chk("stopped", 0, n);
      other_fault = 1'b0;
      output_enable_pin = 1'b1;
      bias_ok_pin = 1'b1;
      vout_sense = 16'hFFFF;
      clear_faults = 1'b1;
      @(posedge clk);
      #1 clear_faults = 1'b0;
      for (int c = 0; c < STEP && output_on !== 1'b1; c++) begin
        @(posedge clk);
        #1;
      end
      chk("on again", 16'h0001, output_on);
    end
    $display("test stop causes done");
    conclude();
  end
endmodule
